// ### logic/mrs_sequencer.sv
// Notes on behaviour
// - reset low stops forwarded clock, holds high
// - hardware reset drives sync, enable, selects high
// - after reset, enable low, eight select pulses
// - then enable high, forwarded clock starts
// - registers default; done flag set at end
// - writing one clears done flag, releases interrupt
// - processor idle until run written with one
// - hardware reset selects the default serial port
// - soft-reset bit resets registers and done flag, defaults zero
// - soft reset keeps port lock and selection
// - soft reset end: self-clear, flag, interrupt
// - soft reset keeps clock, pulses selects
// - clock-disable bit stops forwarded clock high
// - remote reset bit pulses front ends, self-clears
// - both bits power down; registers kept
// - one-bit streams averaged into 24-bit words
// - done interrupt unmaskable until host clears
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "mrs_params.svh"
module mrs_sequencer #(
  parameter int SAMPLE_BITS = `MRS_SAMPLE_BITS,
  parameter int PULSES = `MRS_PULSE_COUNT
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // front-end link
  output logic forwarded_clock_out,
  output logic bitstream_sync_out,
  output logic reset_enable_out,
  output logic phase_a_select_line,
  output logic phase_b_select_line,
  output logic phase_c_select_line,
  output logic neutral_select_line,
  input wire logic modulator_bit_in,
  // host side status
  output logic interrupt_line_one_n,
  output logic processor_running,
  output logic serial_port_is_spi,
  input wire logic spi_select_request,
  // filtered sample
  output logic [SAMPLE_BITS-1:0] sample_word,
  output logic sample_valid
);
  import mrs_pkg::*;

  mrs_state_t state_ff, nxt_state;
  mrs_kind_t kind_ff, nxt_kind;
  logic [15:0] config_ff, configuration_register_two_ff, configuration_register_three_ff, run_ff;
  logic port_spi_ff, done_ff, rdata_valid_ff;
  logic [15:0] rdata_ff;
  logic [1:0] div_ff;
  logic [1:0] phase_ff;
  logic [3:0] pulse_ff;
  logic [3:0] mod_ff;
  logic [SAMPLE_BITS-1:0] acc_ff, sample_ff;
  logic [7:0] avg_ff;
  logic valid_ff;

  // decode
  wire wr_config = reg_wr && reg_addr == `MRS_ADDR_CONFIG;
  wire wr_configuration_register_two = reg_wr && reg_addr == `MRS_ADDR_CONFIGURATION_REGISTER_TWO;
  wire wr_configuration_register_three = reg_wr && reg_addr == `MRS_ADDR_CONFIGURATION_REGISTER_THREE;
  wire wr_status_register_one = reg_wr && reg_addr == `MRS_ADDR_STATUS_REGISTER_ONE;
  wire wr_run = reg_wr && reg_addr == `MRS_ADDR_RUN;
  wire soft_go = wr_config && reg_wdata[`MRS_BIT_SOFT_RESET] && state_ff == MRS_IDLE;
  wire remote_go = wr_configuration_register_three && reg_wdata[`MRS_BIT_REMOTE_RST] && state_ff == MRS_IDLE;
  wire seq_end = state_ff == MRS_DONE;
  wire pulse_last = pulse_ff == 4'(PULSES - 1) && phase_ff == 2'd3;
  wire clr_done = wr_status_register_one && reg_wdata[`MRS_BIT_RESET_DONE];
  wire clk_disabled = configuration_register_three_ff[`MRS_BIT_CLK_DIS];
  // hardware start-up holds the clock until the sequence is back in idle, after the release and done states
  wire clk_held = (kind_ff == MRS_KIND_HW && state_ff != MRS_IDLE) || clk_disabled;

  always_comb begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    unique case (state_ff)
      MRS_IDLE: begin
        if (soft_go) begin
          nxt_state = MRS_ASSERT;
          nxt_kind = MRS_KIND_SW;
        end else if (remote_go) begin
          nxt_state = MRS_ASSERT;
          nxt_kind = MRS_KIND_REMOTE;
        end
      end
      MRS_ASSERT: nxt_state = MRS_PULSE;
      MRS_PULSE: if (pulse_last) nxt_state = MRS_RELEASE;
      MRS_RELEASE: nxt_state = MRS_DONE;
      MRS_DONE: nxt_state = MRS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_ff <= MRS_ASSERT;
      kind_ff <= MRS_KIND_HW;
    end else begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
    end
  end

  // pulse timing: two high, two low, eight pulses
  always_ff @(posedge clock) begin
    if (!resetn || state_ff != MRS_PULSE) begin
      phase_ff <= 2'd0;
      pulse_ff <= 4'd0;
    end else begin
      phase_ff <= phase_ff + 2'd1;
      if (phase_ff == 2'd3) pulse_ff <= pulse_ff + 4'd1;
    end
  end

  wire select_level = !resetn || state_ff != MRS_PULSE || !phase_ff[1];
  assign phase_a_select_line = select_level;
  assign phase_b_select_line = select_level;
  assign phase_c_select_line = select_level;
  assign neutral_select_line = select_level;
  assign reset_enable_out = !resetn || !(state_ff == MRS_ASSERT || state_ff == MRS_PULSE);
  assign bitstream_sync_out = !resetn || clk_held ? 1'b1 : mod_ff[3];

  // forwarded clock at a quarter of the input clock
  always_ff @(posedge clock) begin
    if (!resetn) div_ff <= 2'd0;
    else if (clk_held) div_ff <= 2'd0;
    else div_ff <= div_ff + 2'd1;
  end
  assign forwarded_clock_out = !resetn || clk_held || !div_ff[1];

  // registers; soft reset defaults them but keeps the port lock and choice
  always_ff @(posedge clock) begin
    if (!resetn) begin
      config_ff <= `MRS_RST_CONFIG;
      configuration_register_two_ff <= `MRS_RST_CONFIGURATION_REGISTER_TWO;
      configuration_register_three_ff <= `MRS_RST_CONFIGURATION_REGISTER_THREE;
      run_ff <= `MRS_RST_RUN;
      port_spi_ff <= 1'b0;
    end else begin
      if (soft_go) begin
        config_ff <= `MRS_RST_CONFIG | (16'h0001 << `MRS_BIT_SOFT_RESET);
        configuration_register_two_ff <= configuration_register_two_ff & (16'h0001 << `MRS_BIT_PORT_LOCK);
        configuration_register_three_ff <= `MRS_RST_CONFIGURATION_REGISTER_THREE;
        run_ff <= `MRS_RST_RUN;
      end else begin
        if (wr_config) config_ff <= reg_wdata & ~(16'h0001 << `MRS_BIT_SOFT_RESET);
        if (wr_configuration_register_two) configuration_register_two_ff <= reg_wdata;
        if (wr_run) run_ff <= reg_wdata;
        if (wr_configuration_register_three) configuration_register_three_ff <= reg_wdata;
        if (seq_end) begin
          config_ff[`MRS_BIT_SOFT_RESET] <= 1'b0;
          configuration_register_three_ff[`MRS_BIT_REMOTE_RST] <= 1'b0;
        end
      end
      if (spi_select_request && !configuration_register_two_ff[`MRS_BIT_PORT_LOCK] && !wr_configuration_register_two) port_spi_ff <= 1'b1;
    end
  end
  assign processor_running = run_ff == `MRS_RUN_GO;
  assign serial_port_is_spi = port_spi_ff;

  // done flag; set beats clear, unmaskable
  always_ff @(posedge clock) begin
    if (!resetn) done_ff <= 1'b0;
    else if (seq_end && kind_ff != MRS_KIND_REMOTE) done_ff <= 1'b1;
    else if (clr_done) done_ff <= 1'b0;
    else if (soft_go) done_ff <= 1'b0;
  end
  assign interrupt_line_one_n = !done_ff;

  // read port
  wire [15:0] rd_mux = reg_addr == `MRS_ADDR_CONFIG ? config_ff :
                       reg_addr == `MRS_ADDR_CONFIGURATION_REGISTER_TWO ? configuration_register_two_ff :
                       reg_addr == `MRS_ADDR_CONFIGURATION_REGISTER_THREE ? configuration_register_three_ff :
                       reg_addr == `MRS_ADDR_STATUS_REGISTER_ONE ? {done_ff, 15'h0000} :
                       reg_addr == `MRS_ADDR_RUN ? run_ff :
                       reg_addr == `MRS_ADDR_SAMPLE ? sample_ff[SAMPLE_BITS-1 -: 16] : 16'h0000;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata_ff <= 16'h0000;
      rdata_valid_ff <= 1'b0;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : 16'h0000;
      rdata_valid_ff <= reg_rd;
    end
  end
  assign reg_rdata = rdata_valid_ff ? rdata_ff : 16'h0000;

  // modulator stream sampled every sixteen clocks, averaged by counting ones
  always_ff @(posedge clock) begin
    if (!resetn || clk_held) begin
      mod_ff <= 4'd0;
      avg_ff <= 8'd0;
      acc_ff <= '0;
      sample_ff <= '0;
      valid_ff <= 1'b0;
    end else begin
      mod_ff <= mod_ff + 4'd1;
      valid_ff <= 1'b0;
      if (mod_ff == 4'(`MRS_MOD_DIV - 1)) begin
        avg_ff <= avg_ff + 8'd1;
        if (avg_ff == 8'hff) begin
          sample_ff <= acc_ff + SAMPLE_BITS'(modulator_bit_in);
          acc_ff <= '0;
          valid_ff <= 1'b1;
        end else begin
          acc_ff <= acc_ff + SAMPLE_BITS'(modulator_bit_in);
        end
      end
    end
  end
  assign sample_word = sample_ff;
  assign sample_valid = valid_ff;

  a_pulse_low_two: assert property (@(posedge clock) disable iff (!resetn)
    $fell(phase_a_select_line) |=> !phase_a_select_line ##1 phase_a_select_line)
    else $error("select low time wrong");
  a_enable_low_train: assert property (@(posedge clock) disable iff (!resetn)
    state_ff == MRS_PULSE |-> !reset_enable_out)
    else $error("enable high during pulse train");
  a_train_length: assert property (@(posedge clock) disable iff (!resetn)
    $rose(state_ff == MRS_PULSE) |-> ##31 state_ff == MRS_PULSE ##1 state_ff == MRS_RELEASE)
    else $error("pulse train length wrong");
  a_clk_dis_high: assert property (@(posedge clock) disable iff (!resetn)
    clk_disabled |-> forwarded_clock_out)
    else $error("clock not held high");
  a_done_irq: assert property (@(posedge clock) disable iff (!resetn)
    done_ff && !clr_done && !soft_go |=> !interrupt_line_one_n)
    else $error("interrupt released early");
  a_done_clear: assert property (@(posedge clock) disable iff (!resetn)
    clr_done && !seq_end |=> interrupt_line_one_n)
    else $error("flag not cleared");
  a_soft_selfclr: assert property (@(posedge clock) disable iff (!resetn)
    seq_end && kind_ff == MRS_KIND_SW |=> !config_ff[`MRS_BIT_SOFT_RESET] && done_ff)
    else $error("soft reset end wrong");
  a_remote_selfclr: assert property (@(posedge clock) disable iff (!resetn)
    seq_end && kind_ff == MRS_KIND_REMOTE |=> !configuration_register_three_ff[`MRS_BIT_REMOTE_RST])
    else $error("remote bit not cleared");
  a_lock_kept: assert property (@(posedge clock) disable iff (!resetn)
    soft_go |=> configuration_register_two_ff[`MRS_BIT_PORT_LOCK] == $past(configuration_register_two_ff[`MRS_BIT_PORT_LOCK]))
    else $error("lock changed by soft reset");
  a_sw_clock_runs: assert property (@(posedge clock) disable iff (!resetn)
    state_ff == MRS_PULSE && kind_ff == MRS_KIND_SW && !clk_disabled && div_ff == 2'd2
    |-> !forwarded_clock_out)
    else $error("clock stopped in soft reset");
  a_reset_outs_high: assert property (@(posedge clock)
    !resetn |-> forwarded_clock_out && bitstream_sync_out && reset_enable_out &&
    phase_a_select_line && phase_b_select_line && phase_c_select_line && neutral_select_line)
    else $error("link not held high in reset");
  a_reset_irq_high: assert property (@(posedge clock)
    !resetn |=> interrupt_line_one_n)
    else $error("interrupt low after reset");
  a_reset_run_idle: assert property (@(posedge clock)
    !resetn |=> !processor_running)
    else $error("processor running after reset");
  a_reset_port_i2c: assert property (@(posedge clock)
    !resetn |=> !serial_port_is_spi)
    else $error("port not default after reset");
  a_hw_clock_held: assert property (@(posedge clock) disable iff (!resetn)
    kind_ff == MRS_KIND_HW && state_ff != MRS_IDLE |-> forwarded_clock_out)
    else $error("clock forwarded before start-up end");
  a_idle_lines_high: assert property (@(posedge clock) disable iff (!resetn)
    state_ff == MRS_IDLE |-> reset_enable_out && phase_a_select_line && neutral_select_line)
    else $error("link lines low while idle");
  a_selects_match: assert property (@(posedge clock)
    phase_b_select_line == phase_a_select_line && phase_c_select_line == phase_a_select_line
    && neutral_select_line == phase_a_select_line)
    else $error("select lines differ");
  a_flag_zero_busy: assert property (@(posedge clock) disable iff (!resetn)
    state_ff == MRS_PULSE && kind_ff != MRS_KIND_REMOTE |-> !done_ff)
    else $error("done flag set during sequence");
  a_soft_defaults: assert property (@(posedge clock) disable iff (!resetn)
    soft_go |=> !processor_running && configuration_register_three_ff == `MRS_RST_CONFIGURATION_REGISTER_THREE && !done_ff)
    else $error("soft reset left registers");
  a_soft_port_kept: assert property (@(posedge clock) disable iff (!resetn)
    soft_go && configuration_register_two_ff[`MRS_BIT_PORT_LOCK] |=> $stable(serial_port_is_spi))
    else $error("port changed by soft reset");
  a_remote_run_kept: assert property (@(posedge clock) disable iff (!resetn)
    kind_ff == MRS_KIND_REMOTE && state_ff != MRS_IDLE && !wr_run |=> $stable(run_ff))
    else $error("run lost in front-end reset");
  a_pulse_high_two: assert property (@(posedge clock) disable iff (!resetn)
    $rose(phase_a_select_line) && state_ff == MRS_PULSE |=> phase_a_select_line
    ##1 !phase_a_select_line)
    else $error("select high time wrong");
  a_first_pulse: assert property (@(posedge clock) disable iff (!resetn)
    $rose(state_ff == MRS_PULSE) |-> phase_a_select_line ##1 phase_a_select_line
    ##1 !phase_a_select_line)
    else $error("first select pulse wrong");
  a_release_order: assert property (@(posedge clock) disable iff (!resetn)
    state_ff == MRS_RELEASE |-> reset_enable_out && phase_a_select_line)
    else $error("enable not back after train");
  c_hw_done: cover property (@(posedge clock) seq_end && kind_ff == MRS_KIND_HW);
  c_sw_done: cover property (@(posedge clock) seq_end && kind_ff == MRS_KIND_SW);
  c_remote_done: cover property (@(posedge clock) seq_end && kind_ff == MRS_KIND_REMOTE);
  c_sample: cover property (@(posedge clock) sample_valid);
  c_power_down: cover property (@(posedge clock) state_ff == MRS_PULSE && clk_disabled);
endmodule : mrs_sequencer
`default_nettype wire

// ### logic/mrs_params.svh
`ifndef MRS_PARAMS_SVH
`define MRS_PARAMS_SVH
// register offsets (word addresses on the plain port)
`define MRS_ADDR_CONFIG 8'h00
`define MRS_ADDR_CONFIGURATION_REGISTER_TWO 8'h01
`define MRS_ADDR_CONFIGURATION_REGISTER_THREE 8'h02
`define MRS_ADDR_STATUS_REGISTER_ONE 8'h03
`define MRS_ADDR_RUN 8'h04
`define MRS_ADDR_SAMPLE 8'h05
// field positions
`define MRS_BIT_SOFT_RESET 7
`define MRS_BIT_PORT_LOCK 0
`define MRS_BIT_CLK_DIS 6
`define MRS_BIT_REMOTE_RST 7
`define MRS_BIT_RESET_DONE 15
// reset values
`define MRS_RST_CONFIG 16'h0000
`define MRS_RST_CONFIGURATION_REGISTER_TWO 16'h0000
`define MRS_RST_CONFIGURATION_REGISTER_THREE 16'h0000
`define MRS_RST_RUN 16'h0000
`define MRS_RUN_GO 16'h0001
// timing
`define MRS_CLK_MHZ 40
`define MRS_HW_RESET_MIN_NS 10000
`define MRS_HW_RESET_MIN_CYC ((`MRS_HW_RESET_MIN_NS * `MRS_CLK_MHZ + 999) / 1000)
`define MRS_PULSE_COUNT 8
`define MRS_HALF_PERIOD 2
`define MRS_MOD_DIV 16
`define MRS_SAMPLE_BITS 24
`endif

// ### logic/mrs_pkg.sv
package mrs_pkg;
  typedef enum logic [2:0] {
    MRS_IDLE,
    MRS_ASSERT,
    MRS_PULSE,
    MRS_RELEASE,
    MRS_DONE
  } mrs_state_t;
  typedef enum logic [1:0] {
    MRS_KIND_HW,
    MRS_KIND_SW,
    MRS_KIND_REMOTE
  } mrs_kind_t;
endpackage : mrs_pkg

// ### verification/mrs_front_end_model.sv
`timescale 1ns/1ps
`default_nettype none
module mrs_front_end_model (
  // link from the sequencer
  input wire logic forwarded_clock_out,
  input wire logic reset_enable_out,
  // bit stream back
  output logic modulator_bit_in
);
  // ones while clocked and out of reset, zeros in reset; frozen when the clock stops
  initial modulator_bit_in = 1'b0;
  always @(posedge forwarded_clock_out) modulator_bit_in <= reset_enable_out;
endmodule : mrs_front_end_model
`default_nettype wire

// ### verification/metering_reset_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "mrs_params.svh"
module metering_reset_sequencer_test;
  logic clock, resetn, reg_wr, reg_rd, spi_select_request, modulator_bit_in;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic fclk, sync, ren, sa, sb, sc, sn, irq_n, running, is_spi, valid;
  logic [23:0] sample_word;
  int n_errors = 0, tests_run = 0, cycles = 0, falls_a = 0, falls_n = 0, edges = 0, en_bad = 0;
  mrs_sequencer mrs_sequencer_i (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .forwarded_clock_out(fclk), .bitstream_sync_out(sync), .reset_enable_out(ren),
    .phase_a_select_line(sa), .phase_b_select_line(sb), .phase_c_select_line(sc),
    .neutral_select_line(sn), .modulator_bit_in(modulator_bit_in),
    .interrupt_line_one_n(irq_n), .processor_running(running), .serial_port_is_spi(is_spi),
    .spi_select_request(spi_select_request), .sample_word(sample_word), .sample_valid(valid));
  mrs_front_end_model mrs_front_end_model_i (.forwarded_clock_out(fclk),
    .reset_enable_out(ren), .modulator_bit_in(modulator_bit_in));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(negedge sa) begin
    falls_a++;
    if (ren !== 1'b0) en_bad++;
  end
  always @(negedge sn) falls_n++;
  always @(posedge fclk) edges++;
  // hang guard, well past the longest sequence
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic complete_run();
    if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic wait_done();
    for (int i = 0; i < 200 && irq_n !== 1'b0; i++) @(posedge clock);
    check("irq low", irq_n, 1'b0);
    check("selects a", falls_a, 8);
    check("selects n", falls_n, 8);
    check("enable low", en_bad, 0);
    check("enable back", ren, 1'b1);
  endtask : wait_done
  task automatic hw_reset(input int hold);
    @(posedge clock);
    resetn <= 1'b0;
    repeat (hold) @(posedge clock);
    check("held", {fclk, sync, ren, sa, sb, sc, sn}, 7'h7f);
    check("port", is_spi, 1'b0);
    falls_a = 0;
    falls_n = 0;
    resetn <= 1'b1;
    wait_done();
    check("idle dsp", running, 1'b0);
    rd(`MRS_ADDR_STATUS_REGISTER_ONE, d);
    check("done flag", d[15], 1'b1);
    rd(`MRS_ADDR_CONFIGURATION_REGISTER_TWO, d);
    check("configuration_register_two", d, 16'h0000);
    edges = 0;
    repeat (40) @(posedge clock);
    #1 check("fclk rate", edges, 10);
    wr(`MRS_ADDR_STATUS_REGISTER_ONE, 16'h8000);
    #1 check("irq clear", irq_n, 1'b1);
  endtask : hw_reset
  task automatic soft_reset();
    spi_select_request <= 1'b1;
    @(posedge clock);
    spi_select_request <= 1'b0;
    wr(`MRS_ADDR_CONFIGURATION_REGISTER_TWO, 16'h0001);
    wr(`MRS_ADDR_RUN, 16'h0001);
    #1 check("run", running, 1'b1);
    falls_a = 0;
    falls_n = 0;
    edges = 0;
    wr(`MRS_ADDR_CONFIG, 16'h0080);
    wait_done();
    // 37 clock edges counted at a quarter rate
    check("clock kept", edges >= 9, 1'b1);
    rd(`MRS_ADDR_CONFIG, d);
    check("self clear", d, 16'h0000);
    rd(`MRS_ADDR_RUN, d);
    check("run default", d, 16'h0000);
    rd(`MRS_ADDR_CONFIGURATION_REGISTER_TWO, d);
    check("lock kept", d[0], 1'b1);
    check("port kept", is_spi, 1'b1);
    wr(`MRS_ADDR_STATUS_REGISTER_ONE, 16'h8000);
  endtask : soft_reset
  task automatic remote_reset();
    wr(`MRS_ADDR_RUN, 16'h0001);
    falls_a = 0;
    wr(`MRS_ADDR_CONFIGURATION_REGISTER_THREE, 16'h00c0);
    // the forced-high step on the write edge is not counted
    #1 edges = 0;
    d = 16'h0080;
    for (int i = 0; i < 30 && d[7] !== 1'b0; i++) rd(`MRS_ADDR_CONFIGURATION_REGISTER_THREE, d);
    check("remote clear", d, 16'h0040);
    check("remote pulses", falls_a, 8);
    check("clock stopped", {edges[3:0], fclk}, 5'h01);
    check("core kept", {running, irq_n}, 2'b11);
    wr(`MRS_ADDR_CONFIGURATION_REGISTER_THREE, 16'h0000);
    edges = 0;
    repeat (40) @(posedge clock);
    #1 check("clock back", edges, 10);
  endtask : remote_reset
  task automatic sample_run();
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      for (int i = 0; i < 5000 && valid !== 1'b1; i++) @(posedge clock);
    end
    // second window lies wholly in steady ones
    check("sample", sample_word, 24'd256);
  endtask : sample_run
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    spi_select_request = 1'b0;
    hw_reset(10);
    sample_run();
    soft_reset();
    remote_reset();
    // a full-length reset after the port went to spi
    hw_reset(400);
    complete_run();
  end
endmodule : metering_reset_sequencer_test
`default_nettype wire
